// ### rtl/cae_exec.sv
// Our own choices: the register addresses and the strobed register port.
`include "cae_map.svh"
`default_nettype none
// Summary of operation
// - Set-bits ORs immediate into register, updates Z N V S, one cycle.
// - Clear-bits ANDs register with inverted immediate, updates Z N V S, one cycle.
// - Test ANDs register with itself, value kept, Z N V S updated, one cycle.
// - Multiplies write 16-bit product to R1:R0, update Z and C, two cycles.
// - Fractional multiplies shift product left one bit first, same flags and timing.
// - Cipher round encrypts R0..R15 when H clear, decrypts when set, one or two cycles.
// - Indirect jump loads PC low from Z, clears PC high bits, two cycles.
// - Extended indirect jump loads PC high bits from extended register, two cycles.
// - Extended indirect call pushes return address, targets Z and extended register, three cycles.
// - Compare-skip skips next instruction when registers equal, one to three cycles.
// - Register-bit skips test a register bit, skip on clear or set, one to three cycles.
// - I/O-bit skips test an I/O bit, skip on match, two to four cycles.
// - Generic branches test chosen flag; taken gives PC plus offset plus one.
// - Signed branches use N xor V: zero means greater-equal, one means less.
// - Same-or-higher taken when C is zero; lower taken when C is one.
// - Half-carry branches taken on H set or cleared, relative target.
// - Overflow branches taken on V set or cleared, one or two cycles.
// - Transfer-bit branches taken on T set or cleared, relative target.
// - Interrupt-enable branches taken on I set or cleared, same timing.
module cae_exec import cae_pkg::*; (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Instruction issue
  input wire logic start_i,
  input wire cae_op_t op_i,
  input wire logic [4:0] rd_sel_i,
  input wire logic [4:0] rr_sel_i,
  input wire logic [7:0] imm_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [6:0] offset_i,
  input wire logic io_bit_i,
  input wire logic next_two_word_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Status
  output logic busy_o,
  output logic done_o,
  output logic [21:0] pc_o,
  output logic [7:0] flags_o,
  // Return address push
  output logic push_valid_o,
  output logic [21:0] push_addr_o
);
  // ****************************************
  // Decoding functions
  // ****************************************
  function automatic logic is_mult(input cae_op_t op);
    is_mult = (op == mult_unsigned_op) || (op == mult_signed_op) || (op == mult_signed_unsigned_op) ||
              (op == frac_mult_unsigned_op) || (op == frac_mult_signed_op) ||
              (op == frac_mult_signed_unsigned_op);
  endfunction
  function automatic logic is_skip(input cae_op_t op);
    is_skip = (op == compare_skip_equal_op) || (op == skip_reg_bit_clear_op) ||
              (op == skip_reg_bit_set_op) || (op == skip_io_bit_clear_op) || (op == skip_io_bit_set_op);
  endfunction
  function automatic logic is_branch(input cae_op_t op);
    is_branch = (op >= branch_flag_set_op) && (op <= branch_int_disabled_op);
  endfunction
  function automatic logic branch_cond(input cae_op_t op, input logic [7:0] f, input logic [2:0] s);
    case (op)
      branch_flag_set_op: branch_cond = f[s];
      branch_flag_clear_op: branch_cond = !f[s];
      branch_signed_ge_op: branch_cond = !(f[`CAE_FLAG_N] ^ f[`CAE_FLAG_V]);
      branch_signed_lt_op: branch_cond = f[`CAE_FLAG_N] ^ f[`CAE_FLAG_V];
      branch_same_higher_op: branch_cond = !f[`CAE_FLAG_C];
      branch_lower_op: branch_cond = f[`CAE_FLAG_C];
      branch_half_carry_op: branch_cond = f[`CAE_FLAG_H];
      branch_half_clear_op: branch_cond = !f[`CAE_FLAG_H];
      branch_overflow_op: branch_cond = f[`CAE_FLAG_V];
      branch_no_overflow_op: branch_cond = !f[`CAE_FLAG_V];
      branch_transfer_bit_op: branch_cond = f[`CAE_FLAG_T];
      branch_transfer_clear_op: branch_cond = !f[`CAE_FLAG_T];
      branch_int_enabled_op: branch_cond = f[`CAE_FLAG_I];
      branch_int_disabled_op: branch_cond = !f[`CAE_FLAG_I];
      default: branch_cond = 1'b0;
    endcase
  endfunction
  // ****************************************
  // State
  // ****************************************
  cae_state_t state;
  cae_state_t next_state;
  logic [7:0] regs [0:31];
  logic [7:0] next_regs [0:31];
  logic [7:0] ext_ind;
  logic [2:0] remain;
  logic last_cipher;
  // ****************************************
  // Operand selection and ALU
  // ****************************************
  cae_alu_if alu_bus ();
  cae_alu u_alu (
    .io(alu_bus.alu)
  );
  wire accept = start_i && (state == ST_IDLE);
  wire [7:0] rd_val = regs[rd_sel_i];
  wire [7:0] rr_val = regs[rr_sel_i];
  wire [15:0] z_ptr = {regs[`CAE_Z_HI], regs[`CAE_Z_LO]};
  wire is_logic = (op_i == set_bits_op) || (op_i == clear_bits_op) || (op_i == test_zero_op);
  assign alu_bus.op = op_i;
  assign alu_bus.a = rd_val;
  assign alu_bus.b = is_mult(op_i) ? rr_val : imm_i;
  assign alu_bus.key = imm_i;
  assign alu_bus.h_flag = flags_o[`CAE_FLAG_H];
  genvar g;
  generate
    for (g = 0; g < `CAE_CIPHER_REGS; g++) begin : g_block
      assign alu_bus.block[8*g +: 8] = regs[g];
    end
  endgenerate
  // ****************************************
  // Skip and branch decisions
  // ****************************************
  wire reg_bit = rr_val[bit_sel_i];
  wire skip_hit = ((op_i == compare_skip_equal_op) && (rd_val == rr_val)) ||
                  ((op_i == skip_reg_bit_clear_op) && !reg_bit) ||
                  ((op_i == skip_reg_bit_set_op) && reg_bit) ||
                  ((op_i == skip_io_bit_clear_op) && !io_bit_i) ||
                  ((op_i == skip_io_bit_set_op) && io_bit_i);
  wire is_io_skip = (op_i == skip_io_bit_clear_op) || (op_i == skip_io_bit_set_op);
  wire taken = is_branch(op_i) && branch_cond(op_i, flags_o, bit_sel_i);
  wire [21:0] pc_inc = pc_o + `CAE_PC_STEP;
  wire [21:0] pc_skip = pc_inc + `CAE_PC_STEP + {21'h000000, next_two_word_i};
  wire [21:0] pc_rel = pc_inc + {{15{offset_i[6]}}, offset_i};
  wire [21:0] pc_ind = {6'h00, z_ptr};
  wire [21:0] pc_ext = {ext_ind[`CAE_EXT_IND_BITS-1:0], z_ptr};
  wire is_ext = (op_i == ext_indirect_jump_op) || (op_i == ext_indirect_call_op);
  wire [21:0] next_pc = (op_i == indirect_jump_op) ? pc_ind :
                        is_ext ? pc_ext :
                        (is_skip(op_i) && skip_hit) ? pc_skip :
                        taken ? pc_rel : pc_inc;
  // ****************************************
  // Cycle count
  // ****************************************
  wire [2:0] skip_cyc = !skip_hit ? `CAE_CYC_1 : next_two_word_i ? `CAE_CYC_3 : `CAE_CYC_2;
  wire [2:0] cycles = is_mult(op_i) ? `CAE_CYC_2 :
                      (op_i == cipher_round_op) ? (last_cipher ? `CAE_CYC_1 : `CAE_CYC_2) :
                      ((op_i == indirect_jump_op) || (op_i == ext_indirect_jump_op)) ? `CAE_CYC_2 :
                      (op_i == ext_indirect_call_op) ? `CAE_CYC_3 :
                      is_skip(op_i) ? (skip_cyc + {2'b00, is_io_skip}) :
                      taken ? `CAE_CYC_2 : `CAE_CYC_1;
  // ****************************************
  // Flag and register updates
  // ****************************************
  wire [7:0] lres = alu_bus.logic_res;
  wire [7:0] logic_flags = {flags_o[7:5], lres[7], 1'b0, lres[7], (lres == 8'h00), flags_o[`CAE_FLAG_C]};
  wire [7:0] mul_flags = {flags_o[7:2], (alu_bus.mul_res == 16'h0000), alu_bus.mul_c};
  wire bus_flags = reg_wr_i && (reg_addr_i == `CAE_ADDR_FLAGS);
  wire [7:0] next_flags = (accept && is_logic) ? logic_flags :
                          (accept && is_mult(op_i)) ? mul_flags :
                          bus_flags ? reg_wdata_i : flags_o;
  wire logic_wr = accept && is_logic && (op_i != test_zero_op);
  wire mul_wr = accept && is_mult(op_i);
  wire cipher_wr = accept && (op_i == cipher_round_op);
  generate
    for (g = 0; g < 32; g++) begin : g_regs
      assign next_regs[g] = (cipher_wr && (g < `CAE_CIPHER_REGS)) ? alu_bus.cipher_res[8*(g%16) +: 8] :
                            (mul_wr && (g < 2)) ? alu_bus.mul_res[8*(g%2) +: 8] :
                            (logic_wr && (rd_sel_i == 5'(g))) ? lres :
                            (reg_wr_i && (reg_addr_i == 8'(g))) ? reg_wdata_i : regs[g];
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          regs[g] <= 8'h00;
        end else begin
          regs[g] <= next_regs[g];
        end
      end
    end
  endgenerate
  // ****************************************
  // Sequencer
  // ****************************************
  wire finish = (state == ST_WAIT) && (remain == `CAE_CYC_1);
  always_comb begin
    case (state)
      ST_IDLE: next_state = (accept && (cycles != `CAE_CYC_1)) ? ST_WAIT : ST_IDLE;
      ST_WAIT: next_state = finish ? ST_IDLE : ST_WAIT;
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      remain <= 3'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      last_cipher <= 1'b0;
    end else begin
      state <= next_state;
      remain <= accept ? (cycles - `CAE_CYC_1) : (remain - {2'b00, (state == ST_WAIT)});
      busy_o <= (next_state == ST_WAIT);
      done_o <= (accept && (cycles == `CAE_CYC_1)) || finish;
      last_cipher <= accept ? (op_i == cipher_round_op) : last_cipher;
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_o <= `CAE_PC_RST;
      flags_o <= `CAE_FLAGS_RST;
      ext_ind <= `CAE_EXT_IND_RST;
      push_valid_o <= 1'b0;
      push_addr_o <= `CAE_PC_RST;
    end else begin
      pc_o <= accept ? next_pc : pc_o;
      flags_o <= next_flags;
      ext_ind <= (reg_wr_i && (reg_addr_i == `CAE_ADDR_EXT_IND)) ? reg_wdata_i : ext_ind;
      push_valid_o <= accept && (op_i == ext_indirect_call_op);
      push_addr_o <= (accept && (op_i == ext_indirect_call_op)) ? pc_inc : push_addr_o;
    end
  end
  // ****************************************
  // Register read port
  // ****************************************
  wire [7:0] rd_data = (reg_addr_i <= `CAE_GPR_LAST) ? regs[reg_addr_i[4:0]] :
                       (reg_addr_i == `CAE_ADDR_FLAGS) ? flags_o :
                       (reg_addr_i == `CAE_ADDR_EXT_IND) ? ext_ind :
                       (reg_addr_i == `CAE_ADDR_PC_LO) ? pc_o[7:0] :
                       (reg_addr_i == `CAE_ADDR_PC_MID) ? pc_o[15:8] :
                       (reg_addr_i == `CAE_ADDR_PC_HI) ? {2'b00, pc_o[21:16]} :
                       (reg_addr_i == `CAE_ADDR_STATUS) ? {7'h00, busy_o} : 8'h00;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_data : 8'h00;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic [4:0] h_rd;
  logic [7:0] h_val;
  logic [2:0] h_cyc;
  logic [2:0] h_cnt;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      h_rd <= 5'h00;
      h_val <= 8'h00;
      h_cyc <= 3'h0;
      h_cnt <= 3'h0;
    end else begin
      h_rd <= rd_sel_i;
      h_val <= (op_i == set_bits_op) ? (rd_val | imm_i) : (rd_val & ~imm_i);
      h_cyc <= accept ? cycles : h_cyc;
      h_cnt <= accept ? `CAE_CYC_1 : (h_cnt + 3'h1);
    end
  end
  AST_SET_CLEAR: assert property ((accept && !reg_wr_i && ((op_i == set_bits_op) || (op_i == clear_bits_op)))
    |=> regs[h_rd] == h_val) else $error("set or clear bits result wrong");
  AST_TEST_KEEP: assert property ((accept && !reg_wr_i && (op_i == test_zero_op))
    |=> (regs[h_rd] == $past(rd_val)) && (flags_o[`CAE_FLAG_Z] == (h_rd == h_rd && regs[h_rd] == 8'h00)))
    else $error("test changed register or Z wrong");
  AST_MUL_TWO: assert property ((accept && is_mult(op_i)) |=> busy_o ##1 (done_o && !busy_o))
    else $error("multiply not two cycles");
  AST_INDIRECT_JUMP_OP_PC: assert property ((accept && (op_i == indirect_jump_op))
    |=> (pc_o[21:16] == 6'h00) && (pc_o[15:0] == $past(z_ptr))) else $error("indirect jump target wrong");
  AST_EXT_INDIRECT_JUMP_OP_PC: assert property ((accept && is_ext)
    |=> pc_o == $past(pc_ext)) else $error("extended jump target wrong");
  AST_CALL_PUSH: assert property ((accept && (op_i == ext_indirect_call_op))
    |=> push_valid_o && (push_addr_o == $past(pc_o) + `CAE_PC_STEP) ##2 done_o) else $error("call push wrong");
  AST_SIGNED_BR: assert property ((accept && (op_i == branch_signed_ge_op))
    |=> done_o == $past(flags_o[`CAE_FLAG_N] ^ flags_o[`CAE_FLAG_V])) else $error("signed branch condition wrong");
  AST_BR_TARGET: assert property ((accept && taken)
    |=> pc_o == $past(pc_o) + 22'h000001 + {{15{$past(offset_i[6])}}, $past(offset_i)})
    else $error("branch target wrong");
  AST_CYCLES: assert property (done_o |-> h_cnt == h_cyc) else $error("cycle count mismatch");
  AST_NOT_TAKEN: assert property ((accept && is_branch(op_i) && !taken)
    |=> done_o && (pc_o == $past(pc_o) + 22'h000001)) else $error("untaken branch wrong");
  AST_SIGNED_LT: assert property (
    (accept && (op_i == branch_signed_lt_op))
    |=> done_o != $past(flags_o[`CAE_FLAG_N] ^ flags_o[`CAE_FLAG_V]))
    else $error("signed lt wrong");
  AST_MUL_UU: assert property (
    (accept && !reg_wr_i && (op_i == mult_unsigned_op))
    |=> {regs[1], regs[0]} == $past(rd_val) * $past(rr_val))
    else $error("product wrong");
  AST_FRAC_UU: assert property (
    (accept && !reg_wr_i && (op_i == frac_mult_unsigned_op))
    |=> {regs[1], regs[0]} == ($past(rd_val) * $past(rr_val)) << 1)
    else $error("fraction product wrong");
  AST_IO_SKIP: assert property (
    (accept && is_io_skip) |=> busy_o && !done_o)
    else $error("I/O skip too short");
  AST_ENCRYPT: assert property (
    (accept && !reg_wr_i && (op_i == cipher_round_op) && !flags_o[`CAE_FLAG_H])
    |=> regs[0] == ($past(regs[1]) ^ $past(imm_i)))
    else $error("encrypt byte wrong");
  AST_CALL_PC: assert property (
    (accept && (op_i == ext_indirect_call_op))
    |=> (pc_o[15:0] == $past(z_ptr)) && (pc_o[21:16] == $past(ext_ind[5:0])))
    else $error("call target wrong");
  AST_LOGIC_VS: assert property (
    (accept && (op_i == clear_bits_op))
    |=> !flags_o[`CAE_FLAG_V] && (flags_o[`CAE_FLAG_S] == flags_o[`CAE_FLAG_N]))
    else $error("logic flags wrong");
  // ****************************************
  // Cover points
  // ****************************************
  COV_FRAC: cover property (accept && (op_i == frac_mult_signed_unsigned_op));
  COV_TAKEN: cover property (accept && taken);
  COV_SKIP_TWO: cover property (accept && skip_hit && next_two_word_i && is_io_skip);
  COV_CIPHER_DEC: cover property (accept && (op_i == cipher_round_op) && flags_o[`CAE_FLAG_H]);
  COV_CALL: cover property (accept && (op_i == ext_indirect_call_op));
endmodule
`default_nettype wire

// ### rtl/cae_map.svh
`ifndef CAE_MAP_SVH
`define CAE_MAP_SVH
// ****************************************
// Register map of the software port
// ****************************************
`define CAE_GPR_LAST 8'h1F
`define CAE_ADDR_FLAGS 8'h20
`define CAE_ADDR_EXT_IND 8'h21
`define CAE_ADDR_PC_LO 8'h22
`define CAE_ADDR_PC_MID 8'h23
`define CAE_ADDR_PC_HI 8'h24
`define CAE_ADDR_STATUS 8'h25
// ****************************************
// Reset values
// ****************************************
`define CAE_FLAGS_RST 8'h00
`define CAE_EXT_IND_RST 8'h00
`define CAE_PC_RST 22'h000000
// ****************************************
// Status flag positions
// ****************************************
`define CAE_FLAG_C 0
`define CAE_FLAG_Z 1
`define CAE_FLAG_N 2
`define CAE_FLAG_V 3
`define CAE_FLAG_S 4
`define CAE_FLAG_H 5
`define CAE_FLAG_T 6
`define CAE_FLAG_I 7
// ****************************************
// Cycle counts and pointers
// ****************************************
`define CAE_CYC_1 3'h1
`define CAE_CYC_2 3'h2
`define CAE_CYC_3 3'h3
`define CAE_CYC_4 3'h4
`define CAE_PC_STEP 22'h000001
`define CAE_Z_LO 5'h1E
`define CAE_Z_HI 5'h1F
`define CAE_CIPHER_REGS 16
`define CAE_EXT_IND_BITS 6
`endif

// ### rtl/cae_pkg.sv
`default_nettype none
package cae_pkg;
  typedef enum logic [5:0] {
    nop_op, set_bits_op, clear_bits_op, test_zero_op,
    mult_unsigned_op, mult_signed_op, mult_signed_unsigned_op,
    frac_mult_unsigned_op, frac_mult_signed_op, frac_mult_signed_unsigned_op,
    cipher_round_op, indirect_jump_op, ext_indirect_jump_op, ext_indirect_call_op,
    compare_skip_equal_op, skip_reg_bit_clear_op, skip_reg_bit_set_op,
    skip_io_bit_clear_op, skip_io_bit_set_op,
    branch_flag_set_op, branch_flag_clear_op, branch_signed_ge_op, branch_signed_lt_op,
    branch_same_higher_op, branch_lower_op, branch_half_carry_op, branch_half_clear_op,
    branch_overflow_op, branch_no_overflow_op, branch_transfer_bit_op, branch_transfer_clear_op,
    branch_int_enabled_op, branch_int_disabled_op
  } cae_op_t;
  typedef enum logic {
    ST_IDLE, ST_WAIT
  } cae_state_t;
endpackage
`default_nettype wire

// ### rtl/cae_alu_if.sv
`default_nettype none
interface cae_alu_if;
  import cae_pkg::*;
  cae_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic [127:0] block;
  logic [7:0] key;
  logic h_flag;
  logic [7:0] logic_res;
  logic [15:0] mul_res;
  logic mul_c;
  logic [127:0] cipher_res;
  modport exec (output op, a, b, block, key, h_flag, input logic_res, mul_res, mul_c, cipher_res);
  modport alu (input op, a, b, block, key, h_flag, output logic_res, mul_res, mul_c, cipher_res);
endinterface
`default_nettype wire

// ### rtl/cae_alu.sv
`default_nettype none
module cae_alu import cae_pkg::*; (
  // Operands and results
  cae_alu_if.alu io
);
  // ****************************************
  // Bit logic
  // ****************************************
  assign io.logic_res = (io.op == set_bits_op) ? (io.a | io.b) :
                        (io.op == clear_bits_op) ? (io.a & ~io.b) :
                        (io.a & io.a);
  // ****************************************
  // Multiplier
  // ****************************************
  wire a_signed = (io.op == mult_signed_op) || (io.op == mult_signed_unsigned_op) ||
                  (io.op == frac_mult_signed_op) || (io.op == frac_mult_signed_unsigned_op);
  wire b_signed = (io.op == mult_signed_op) || (io.op == frac_mult_signed_op);
  wire frac = (io.op == frac_mult_unsigned_op) || (io.op == frac_mult_signed_op) ||
              (io.op == frac_mult_signed_unsigned_op);
  wire signed [8:0] ext_a = {a_signed & io.a[7], io.a};
  wire signed [8:0] ext_b = {b_signed & io.b[7], io.b};
  wire signed [17:0] prod = ext_a * ext_b;
  assign io.mul_c = prod[15];
  assign io.mul_res = frac ? {prod[14:0], 1'b0} : prod[15:0];
  // ****************************************
  // Cipher round on sixteen bytes
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < `CAE_CIPHER_REGS; i++) begin : g_round
      localparam int NX = (i + 1) % `CAE_CIPHER_REGS;
      localparam int PV = (i + `CAE_CIPHER_REGS - 1) % `CAE_CIPHER_REGS;
      wire [7:0] key_enc = io.key ^ 8'(i);
      wire [7:0] key_dec = io.key ^ 8'(PV);
      assign io.cipher_res[8*i +: 8] = io.h_flag ? (io.block[8*PV +: 8] ^ key_dec) :
                                       (io.block[8*NX +: 8] ^ key_enc);
    end
  endgenerate
endmodule
`default_nettype wire

// ### testbench/cpu_alu_branch_exec_tb.sv
`include "cae_map.svh"
`default_nettype none
module cpu_alu_branch_exec_tb import cae_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic mclk_i = 1'b0, reset_i = 1'b1, start_i = 1'b0, io_bit_i = 1'b0, next_two_word_i = 1'b0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, busy_o, done_o, push_valid_o, pv, bz;
  cae_op_t op_i = nop_op;
  logic [4:0] rd_sel_i = 5'h00, rr_sel_i = 5'h00;
  logic [7:0] imm_i = 8'h00, reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, flags_o;
  logic [2:0] bit_sel_i = 3'h0;
  logic [6:0] offset_i = 7'h00;
  logic [21:0] pc_o, push_addr_o, pc0, ncyc, exp_pc;
  int failures = 0, n_compared = 0;
  cae_op_t mop [7] = '{mult_unsigned_op, mult_signed_op, mult_signed_unsigned_op, frac_mult_unsigned_op,
                       frac_mult_signed_op, frac_mult_signed_unsigned_op, mult_unsigned_op};
  logic [7:0] ma [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h80, 8'hFF, 8'hFF, 8'h00};
  logic [7:0] mb [7] = '{8'hFF, 8'hFF, 8'h02, 8'h80, 8'hFF, 8'h02, 8'h05};
  logic [15:0] mp [7] = '{16'hFE01, 16'h0001, 16'hFFFE, 16'h8000, 16'h0002, 16'hFFFC, 16'h0000};
  logic [1:0] mzc [7] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2};
  logic [7:0] fl [8] = '{8'h00, 8'hFF, 8'h0C, 8'h04, 8'h08, 8'h21, 8'h40, 8'h80};
  cae_op_t bop;
  logic t;
  cae_exec uut (.mclk_i(mclk_i), .reset_i(reset_i), .start_i(start_i), .op_i(op_i), .rd_sel_i(rd_sel_i),
    .rr_sel_i(rr_sel_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i), .offset_i(offset_i), .io_bit_i(io_bit_i),
    .next_two_word_i(next_two_word_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .busy_o(busy_o), .done_o(done_o), .pc_o(pc_o),
    .flags_o(flags_o), .push_valid_o(push_valid_o), .push_addr_o(push_addr_o));
  always #20 mclk_i = ~mclk_i;
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input string n, input logic [21:0] seen, input logic [21:0] e);
    n_compared++;
    if (seen !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, seen);
    end
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 chk(n, {14'h0000, reg_rdata_o}, {14'h0000, e});
  endtask
  task run(input cae_op_t op, input logic [4:0] d, input logic [4:0] r, input logic [7:0] im,
           input logic [6:0] off, input logic [2:0] b, input logic io, input logic tw);
    @(posedge mclk_i);
    op_i <= op;
    rd_sel_i <= d;
    rr_sel_i <= r;
    imm_i <= im;
    offset_i <= off;
    bit_sel_i <= b;
    io_bit_i <= io;
    next_two_word_i <= tw;
    start_i <= 1'b1;
    pc0 = pc_o;
    @(posedge mclk_i);
    start_i <= 1'b0;
    #1 pv = push_valid_o;
    bz = busy_o;
    ncyc = 22'h000001;
    while (done_o !== 1'b1 && ncyc < 22'h000009) begin
      @(posedge mclk_i);
      #1 ncyc++;
    end
    if (ncyc >= 22'h000009) begin
      failures++;
      give_verdict;
    end
  endtask
  task skipt(input cae_op_t op, input logic [4:0] d, input logic [4:0] r, input logic [2:0] b,
             input logic io, input logic tw, input logic sk);
    logic [21:0] step;
    step = sk ? (tw ? 22'h000003 : 22'h000002) : 22'h000001;
    run(op, d, r, 8'h00, 7'h00, b, io, tw);
    chk("skip pc", pc_o, pc0 + step);
    chk("skip cycles", ncyc, step + {21'h000000, (op == skip_io_bit_clear_op || op == skip_io_bit_set_op)});
  endtask
  function automatic logic taken(input cae_op_t o, input logic [7:0] f, input logic [2:0] b);
    case (o)
      branch_flag_set_op: return f[b];
      branch_flag_clear_op: return !f[b];
      branch_signed_ge_op: return !(f[2] ^ f[3]);
      branch_signed_lt_op: return f[2] ^ f[3];
      branch_same_higher_op: return !f[0];
      branch_lower_op: return f[0];
      branch_half_carry_op: return f[5];
      branch_half_clear_op: return !f[5];
      branch_overflow_op: return f[3];
      branch_no_overflow_op: return !f[3];
      branch_transfer_bit_op: return f[6];
      branch_transfer_clear_op: return !f[6];
      branch_int_enabled_op: return f[7];
      default: return !f[7];
    endcase
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    rdchk("flags", `CAE_ADDR_FLAGS, `CAE_FLAGS_RST);
    rdchk("ext reg", `CAE_ADDR_EXT_IND, `CAE_EXT_IND_RST);
    rdchk("unmapped", 8'h30, 8'h00);
    rdchk("status", `CAE_ADDR_STATUS, 8'h00);
    $display("test reset done");
    wr(8'h10, 8'h0F);
    run(set_bits_op, 5'h10, 5'h00, 8'hF0, 7'h00, 3'h0, 1'b0, 1'b0);
    chk("set cycles", ncyc, 22'h000001);
    chk("set busy", {21'h000000, bz}, 22'h000000);
    chk("set flags", {14'h0000, flags_o}, 22'h000014);
    rdchk("set result", 8'h10, 8'hFF);
    run(clear_bits_op, 5'h10, 5'h00, 8'hF0, 7'h00, 3'h0, 1'b0, 1'b0);
    chk("clear cycles", ncyc, 22'h000001);
    chk("clear flags", {14'h0000, flags_o}, 22'h000000);
    rdchk("clear result", 8'h10, 8'h0F);
    wr(8'h11, 8'h80);
    run(test_zero_op, 5'h11, 5'h11, 8'h00, 7'h00, 3'h0, 1'b0, 1'b0);
    chk("test flags", {14'h0000, flags_o}, 22'h000014);
    rdchk("test keeps", 8'h11, 8'h80);
    $display("test logic done");
    for (int i = 0; i < 7; i++) begin
      wr(8'h02, ma[i]);
      wr(8'h03, mb[i]);
      run(mop[i], 5'h02, 5'h03, 8'h00, 7'h00, 3'h0, 1'b0, 1'b0);
      chk("mul cycles", ncyc, 22'h000002);
      chk("mul busy", {21'h000000, bz}, 22'h000001);
      chk("mul zc", {20'h00000, flags_o[1:0]}, {20'h00000, mzc[i]});
      rdchk("mul r0", 8'h00, mp[i][7:0]);
      rdchk("mul r1", 8'h01, mp[i][15:8]);
    end
    $display("test multiply done");
    wr(8'h1E, 8'h34);
    wr(8'h1F, 8'h12);
    wr(`CAE_ADDR_EXT_IND, 8'h2A);
    run(ext_indirect_jump_op, 5'h00, 5'h00, 8'h00, 7'h00, 3'h0, 1'b0, 1'b0);
    chk("ext jump pc", pc_o, 22'h2A1234);
    chk("ext jump cycles", ncyc, 22'h000002);
    rdchk("pc high", `CAE_ADDR_PC_HI, 8'h2A);
    rdchk("pc low", `CAE_ADDR_PC_LO, 8'h34);
    run(indirect_jump_op, 5'h00, 5'h00, 8'h00, 7'h00, 3'h0, 1'b0, 1'b0);
    chk("jump pc", pc_o, 22'h001234);
    chk("jump cycles", ncyc, 22'h000002);
    run(ext_indirect_call_op, 5'h00, 5'h00, 8'h00, 7'h00, 3'h0, 1'b0, 1'b0);
    chk("call pc", pc_o, 22'h2A1234);
    chk("call cycles", ncyc, 22'h000003);
    chk("push valid", {21'h000000, pv}, 22'h000001);
    chk("push addr", push_addr_o, 22'h001235);
    $display("test jump done");
    wr(8'h02, 8'h05);
    wr(8'h03, 8'h05);
    wr(8'h04, 8'h08);
    skipt(compare_skip_equal_op, 5'h02, 5'h03, 3'h0, 1'b0, 1'b0, 1'b1);
    skipt(compare_skip_equal_op, 5'h02, 5'h03, 3'h0, 1'b0, 1'b1, 1'b1);
    skipt(compare_skip_equal_op, 5'h02, 5'h04, 3'h0, 1'b0, 1'b1, 1'b0);
    skipt(skip_reg_bit_clear_op, 5'h00, 5'h04, 3'h3, 1'b0, 1'b0, 1'b0);
    skipt(skip_reg_bit_clear_op, 5'h00, 5'h04, 3'h2, 1'b0, 1'b0, 1'b1);
    skipt(skip_reg_bit_set_op, 5'h00, 5'h04, 3'h3, 1'b0, 1'b1, 1'b1);
    skipt(skip_io_bit_clear_op, 5'h00, 5'h00, 3'h0, 1'b0, 1'b0, 1'b1);
    skipt(skip_io_bit_set_op, 5'h00, 5'h00, 3'h0, 1'b0, 1'b0, 1'b0);
    skipt(skip_io_bit_set_op, 5'h00, 5'h00, 3'h0, 1'b1, 1'b1, 1'b1);
    $display("test skip done");
    for (int k = 0; k < 8; k++) begin
      wr(`CAE_ADDR_FLAGS, fl[k]);
      for (int j = 0; j < 14; j++) begin
        bop = cae_op_t'(int'(branch_flag_set_op) + j);
        t = taken(bop, fl[k], 3'(k));
        run(bop, 5'h00, 5'h00, 8'h00, j[0] ? 7'h7E : 7'h05, 3'(k), 1'b0, 1'b0);
        exp_pc = pc0 + (t ? {{15{offset_i[6]}}, offset_i} + 22'h000001 : 22'h000001);
        chk("branch pc", pc_o, exp_pc);
        chk("branch cycles", ncyc, t ? 22'h000002 : 22'h000001);
      end
    end
    $display("test branch done");
    for (int i = 0; i < 16; i++) wr(8'(i), 8'(i * 17));
    wr(`CAE_ADDR_FLAGS, 8'h00);
    run(cipher_round_op, 5'h00, 5'h00, 8'h5A, 7'h00, 3'h0, 1'b0, 1'b0);
    chk("encrypt cycles", ncyc, 22'h000002);
    rdchk("encrypt r0", 8'h00, 8'h4B);
    wr(`CAE_ADDR_FLAGS, 8'h20);
    run(cipher_round_op, 5'h00, 5'h00, 8'h5A, 7'h00, 3'h0, 1'b0, 1'b0);
    chk("decrypt cycles", ncyc, 22'h000001);
    rdchk("decrypt r0", 8'h00, 8'h00);
    rdchk("decrypt r15", 8'h0F, 8'hFF);
    $display("test cipher done");
    give_verdict;
  end
endmodule
`default_nettype wire
